// file: event_source_model.sv
// far side: interrupt controller, system bus and core sequencer events
// assumes the bench requests events just after clock_in edges
`timescale 1ns/1ps
module event_source_model (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic [8:0] req_in,
  output logic      [8:0] ev_out
);
  // each request leaves one cycle later and stays up as long as it is held, quiet during reset
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ev_out <= 9'h000;
    end else begin
      ev_out <= req_in;
    end
  end
endmodule

// file: privilege_state_control.sv
// processor state, privilege level, stack pointer select and function codes
// assumes core sequencing drives the event inputs on clock_in; APB master on clock_in
`timescale 1ns/1ps
`include "privilege_state_control_defs.svh"
module privilege_state_control
  import privilege_state_control_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        irq_ack_in,
  input  wire logic        trace_in,
  input  wire logic        trap_in,
  input  wire logic        other_exc_in,
  input  wire logic        bus_error_in,
  input  wire logic        address_error_in,
  input  wire logic        handler_start_in,
  input  wire logic        stop_in,
  input  wire logic        resume_in,
  input  wire logic        instr_valid_in,
  input  wire logic        instr_privileged_in,
  input  wire logic [2:0]  sr_op_in,
  input  wire logic [15:0] sr_operand_in,
  input  wire logic        program_access_in,
  input  wire logic        cpu_space_in,
  input  wire logic        mmu_enable_in,
  input  wire logic        paddr_valid_unused_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [2:0]  function_code_outputs_out,
  output logic      [1:0]  stack_select_out,
  output logic             supervisor_out,
  output logic             halted_out,
  output logic             stopped_out,
  output logic             bus_cycles_enable_out,
  output logic             privilege_violation_out,
  output logic             pipeline_indication_a_out,
  output logic             sr_pushed_out,
  output logic      [15:0] pushed_status_out,
  output logic             user_block_out
);
  localparam int pipeline_indication_a_cycles = (`PIPELINE_INDICATION_A_CYCLES < 1) ? 1 : `PIPELINE_INDICATION_A_CYCLES;

  proc_state_t state;
  proc_state_t next_state;
  logic [15:0] status_register;
  logic [15:0] next_status_register;
  logic [15:0] saved_status;
  logic        stopped;
  logic        irq_cause;
  logic        sw_protect;
  logic [7:0]  pipeline_indication_a_count;

  wire s_bit       = status_register[`SR_S_BIT];
  wire m_bit       = status_register[`SR_M_BIT];
  wire exc_request = irq_ack_in | trace_in | trap_in | other_exc_in;
  wire fault       = bus_error_in | address_error_in;
  wire priv_try    = instr_valid_in & instr_privileged_in;
  wire priv_viol   = priv_try & ~s_bit;
  wire sr_write    = priv_try & s_bit & (sr_op_t'(sr_op_in) != op_none);
  wire apb_access  = psel & penable;

  // state transitions; halt has no exit but rst_in
  always_comb begin
    next_state = state;
    case (state)
      st_normal: begin
        if (exc_request | fault | priv_viol) begin
          next_state = st_exception;
        end
      end
      st_exception: begin
        if (fault) begin
          next_state = st_halted;
        end else if (handler_start_in) begin
          next_state = st_normal;
        end
      end
      st_halted: begin
        next_state = st_halted;
      end
      default: begin
        next_state = st_halted;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= st_normal;
    end else begin
      state <= next_state;
    end
  end

  // status register: five instruction kinds, exception entry, reset
  always_comb begin
    next_status_register = status_register;
    if (state == st_normal && next_state == st_exception) begin
      next_status_register[`SR_S_BIT] = 1'b1;
      if (irq_ack_in) begin
        next_status_register[`SR_M_BIT] = 1'b0;
      end
    end else if (state == st_normal && sr_write) begin
      case (sr_op_t'(sr_op_in))
        op_move_to_sr: next_status_register = sr_operand_in;
        op_and_imm_sr: next_status_register = status_register & sr_operand_in;
        op_xor_imm_sr: next_status_register = status_register ^ sr_operand_in;
        op_or_imm_sr:  next_status_register = status_register | sr_operand_in;
        op_return_exc: next_status_register = sr_operand_in;
        default:       next_status_register = status_register;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      status_register <= `SR_RESET_VALUE;
    end else begin
      status_register <= next_status_register;
    end
  end

  // old status captured before the supervisor bit is forced
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      saved_status  <= 16'h0000;
      sr_pushed_out <= 1'b0;
      irq_cause     <= 1'b0;
    end else begin
      sr_pushed_out <= 1'b0;
      if (state == st_normal && next_state == st_exception) begin
        saved_status  <= status_register;
        sr_pushed_out <= 1'b1;
        irq_cause     <= irq_ack_in;
      end
    end
  end

  // stopped is normal processing without bus cycles
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      stopped <= 1'b0;
    end else if (state != st_normal || next_state != st_normal || resume_in) begin
      stopped <= 1'b0;
    end else if (stop_in && s_bit) begin
      stopped <= 1'b1;
    end
  end

  // pipeline_indication_a indication held for a minimum pulse after status writes
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pipeline_indication_a_count <= 8'h00;
    end else if (state == st_normal && sr_write) begin
      pipeline_indication_a_count <= 8'(pipeline_indication_a_cycles);
    end else if (pipeline_indication_a_count != 8'h00) begin
      pipeline_indication_a_count <= pipeline_indication_a_count - 8'h01;
    end
  end

  // function code and stack pointer select follow the next status value
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      function_code_outputs_out <= `FC_SUPER_PROGRAM;
      stack_select_out          <= sp_interrupt;
      supervisor_out            <= 1'b1;
      user_block_out            <= 1'b0;
    end else begin
      supervisor_out <= next_status_register[`SR_S_BIT] | (next_state == st_exception);
      if (cpu_space_in) begin
        function_code_outputs_out <= `FC_CPU_SPACE;
      end else if (next_status_register[`SR_S_BIT] || next_state == st_exception) begin
        function_code_outputs_out <= program_access_in ? `FC_SUPER_PROGRAM : `FC_SUPER_DATA;
      end else begin
        function_code_outputs_out <= program_access_in ? `FC_USER_PROGRAM : `FC_USER_DATA;
      end
      if (!next_status_register[`SR_S_BIT] && next_state != st_exception) begin
        stack_select_out <= sp_user;
      end else if (next_status_register[`SR_M_BIT]) begin
        stack_select_out <= sp_master;
      end else begin
        stack_select_out <= sp_interrupt;
      end
      user_block_out <= mmu_enable_in & sw_protect & ~next_status_register[`SR_S_BIT];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      halted_out                <= 1'b0;
      stopped_out               <= 1'b0;
      bus_cycles_enable_out     <= 1'b1;
      privilege_violation_out   <= 1'b0;
      pipeline_indication_a_out <= 1'b0;
      pushed_status_out         <= 16'h0000;
    end else begin
      halted_out                <= (state == st_halted);
      stopped_out               <= stopped;
      bus_cycles_enable_out     <= (state != st_halted) & ~stopped;
      privilege_violation_out   <= (state == st_normal) & priv_viol;
      pipeline_indication_a_out <= (pipeline_indication_a_count != 8'h00);
      pushed_status_out         <= saved_status;
    end
  end

  // apb slave, zero wait states; unmapped reads zero with error
  wire addr_known = (paddr == `OFF_CONTROL) || (paddr == `OFF_STATUS_REG) ||
                    (paddr == `OFF_PROC_STATE) || (paddr == `OFF_SAVED_STATUS) ||
                    (paddr == `OFF_STACK_SELECT);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sw_protect <= 1'b0;
    end else if (apb_access && pwrite && paddr == `OFF_CONTROL) begin
      sw_protect <= pwdata[0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_known;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `OFF_CONTROL:      prdata <= {31'h0, sw_protect};
          `OFF_STATUS_REG:   prdata <= {16'h0, status_register};
          `OFF_PROC_STATE:   prdata <= {28'h0, stopped, state};
          `OFF_SAVED_STATUS: prdata <= {15'h0, irq_cause, saved_status};
          `OFF_STACK_SELECT: prdata <= {30'h0, stack_select_out};
          default:           prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// file: privilege_state_control_defs.svh
// constants for the processor state and privilege controller
// assumes a single 50 MHz clock and an APB register slave
`ifndef PRIVILEGE_STATE_CONTROL_DEFS_SVH
`define PRIVILEGE_STATE_CONTROL_DEFS_SVH
`define OFF_CONTROL        12'h000
`define OFF_STATUS_REG     12'h004
`define OFF_PROC_STATE     12'h008
`define OFF_SAVED_STATUS   12'h00c
`define OFF_STACK_SELECT   12'h010
`define SR_S_BIT           13
`define SR_M_BIT           12
`define SR_RESET_VALUE     16'h2700
`define FC_USER_DATA       3'h1
`define FC_USER_PROGRAM    3'h2
`define FC_SUPER_DATA      3'h5
`define FC_SUPER_PROGRAM   3'h6
`define FC_CPU_SPACE       3'h7
`define PIPELINE_INDICATION_A_PULSE_NS    20
`define CLOCK_MHZ          50
`define PIPELINE_INDICATION_A_CYCLES      (((`PIPELINE_INDICATION_A_PULSE_NS * `CLOCK_MHZ) + 999) / 1000)
`endif

// file: privilege_state_control_pkg.sv
// types for the processor state and privilege controller
// used by privilege_state_control, its assertions and the bench
package privilege_state_control_pkg;
  typedef enum logic [2:0] {
    st_normal    = 3'b001,
    st_exception = 3'b010,
    st_halted    = 3'b100
  } proc_state_t;
  typedef enum logic [2:0] {
    op_none        = 3'h0,
    op_move_to_sr  = 3'h1,
    op_and_imm_sr  = 3'h2,
    op_xor_imm_sr  = 3'h3,
    op_or_imm_sr   = 3'h4,
    op_return_exc  = 3'h5
  } sr_op_t;
  typedef enum logic [1:0] {
    sp_user      = 2'h0,
    sp_interrupt = 2'h1,
    sp_master    = 2'h2
  } stack_sel_t;
endpackage

// file: privilege_state_control_props.sv
// assertions on the ports of the state and privilege controller
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/1ps
module privilege_state_control_props
  import privilege_state_control_pkg::*;
(
  input wire logic       clock_in,
  input wire logic       rst_in,
  input wire logic       irq_ack_in,
  input wire logic       bus_error_in,
  input wire logic       handler_start_in,
  input wire logic       instr_valid_in,
  input wire logic       instr_privileged_in,
  input wire logic [2:0] function_code_outputs_out,
  input wire logic [1:0] stack_select_out,
  input wire logic       supervisor_out,
  input wire logic       halted_out,
  input wire logic       stopped_out,
  input wire logic       bus_cycles_enable_out,
  input wire logic       privilege_violation_out,
  input wire logic       pipeline_indication_a_out,
  input wire logic       sr_pushed_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_enter;
    irq_ack_in && !halted_out;
  endsequence
  sequence s_fault;
    s_enter ##1 (bus_error_in && !handler_start_in);
  endsequence
  a_halt_sticky: assert property (halted_out |=> halted_out)
    else $error("halt left without reset");
  a_fault_halt: assert property (s_fault |-> ##[1:2] halted_out)
    else $error("fault in exception did not halt");
  a_irq_entry: assert property (s_enter |-> ##[1:2] (sr_pushed_out && supervisor_out
    && stack_select_out == sp_interrupt)) else $error("interrupt entry wrong");
  a_fc_space: assert property (function_code_outputs_out[2]
    == (supervisor_out || function_code_outputs_out == 3'h7)) else $error("function code level");
  a_stack_pick: assert property (supervisor_out != (stack_select_out == sp_user))
    else $error("stack select disagrees with level");
  a_bus_quiet: assert property ((halted_out || stopped_out) |-> !bus_cycles_enable_out)
    else $error("bus cycles while halted or stopped");
  a_stop_distinct: assert property (stopped_out |-> !halted_out)
    else $error("stopped and halted together");
  a_user_trap: assert property (instr_valid_in && instr_privileged_in && !supervisor_out
    && !halted_out |-> ##[1:2] privilege_violation_out) else $error("no violation at user");
  a_sup_quiet: assert property (instr_valid_in && instr_privileged_in && supervisor_out
    |=> !privilege_violation_out [*2]) else $error("violation at supervisor");
  a_pipeline_indication_a_once: assert property (pipeline_indication_a_out |=> !pipeline_indication_a_out)
    else $error("pipeline_indication_a pulse too long");
endmodule
bind privilege_state_control privilege_state_control_props privilege_state_control_props_inst (.*);

// file: tb.sv
// self-checking bench for the state and privilege controller
// assumes APB answers by pready; events come from event_source_model
`timescale 1ns/1ps
`include "privilege_state_control_defs.svh"
module tb;
  import privilege_state_control_pkg::*;
  logic        clock_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic        instr_valid_in = 0, instr_privileged_in = 0, program_access_in = 0;
  logic        cpu_space_in = 0, mmu_enable_in = 0, paddr_valid_unused_in = 0;
  logic        irq_ack_in, trace_in, trap_in, other_exc_in, bus_error_in, address_error_in;
  logic        handler_start_in, stop_in, resume_in, pready, pslverr, supervisor_out;
  logic        halted_out, stopped_out, bus_cycles_enable_out, privilege_violation_out;
  logic        pipeline_indication_a_out, sr_pushed_out, user_block_out;
  logic [2:0]  sr_op_in = 0, function_code_outputs_out;
  logic [1:0]  stack_select_out;
  logic [8:0]  req = 0, ev;
  logic [11:0] paddr = 0;
  logic [15:0] sr_operand_in = 0, pushed_status_out;
  logic [31:0] pwdata = 0, prdata, rd;
  int          err_count = 0, compares = 0, refills = 0;
  sr_op_t      ops[5] = '{op_move_to_sr, op_and_imm_sr, op_or_imm_sr, op_xor_imm_sr, op_return_exc};
  logic [15:0] vals[5] = '{16'h3700, 16'h2fff, 16'h1000, 16'h1000, 16'h3700};
  logic [15:0] exps[5] = '{16'h3700, 16'h2700, 16'h3700, 16'h2700, 16'h3700};
  assign {resume_in, stop_in, handler_start_in, address_error_in, bus_error_in,
          other_exc_in, trap_in, trace_in, irq_ack_in} = ev;
  event_source_model event_source_model_inst (.clock_in, .rst_in, .req_in(req), .ev_out(ev));
  privilege_state_control privilege_state_control_inst (.*);
  always #10 clock_in = ~clock_in;
  always @(posedge clock_in) if (pipeline_indication_a_out === 1'b1) refills++;
  task end_sim();
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clock_in);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_in);
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task evs(input logic [8:0] a, input logic [8:0] b);
    req <= a;
    @(posedge clock_in);
    req <= b;
    @(posedge clock_in);
    req <= 9'h000;
    repeat (4) @(posedge clock_in);
  endtask
  task ins(input logic p, input logic [2:0] op, input logic [15:0] v);
    instr_valid_in      <= 1'b1;
    instr_privileged_in <= p;
    sr_op_in            <= op;
    sr_operand_in       <= v;
    @(posedge clock_in);
    instr_valid_in <= 1'b0;
    sr_op_in       <= 3'h0;
    repeat (4) @(posedge clock_in);
  endtask
  initial begin
    #20000;
    err_count++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    program_access_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rdchk(`OFF_STATUS_REG, `SR_RESET_VALUE);
    rdchk(`OFF_STACK_SELECT, 32'h1);
    rdchk(`OFF_PROC_STATE, 32'h1);
    chk(function_code_outputs_out, `FC_SUPER_PROGRAM);
    for (int i = 0; i < 5; i++) begin
      ins(1'b1, ops[i], vals[i]);
      rdchk(`OFF_STATUS_REG, {16'h0, exps[i]});
      chk(stack_select_out, exps[i][12] ? sp_master : sp_interrupt);
    end
    chk(refills, 5);
    evs(9'h001, 9'h000);
    rdchk(`OFF_SAVED_STATUS, 32'h13700);
    chk(pushed_status_out, 16'h3700);
    rdchk(`OFF_STATUS_REG, 32'h2700);
    rdchk(`OFF_PROC_STATE, 32'h2);
    evs(9'h040, 9'h000);
    rdchk(`OFF_PROC_STATE, 32'h1);
    evs(9'h00e, 9'h000);
    rdchk(`OFF_PROC_STATE, 32'h2);
    rdchk(`OFF_SAVED_STATUS, 32'h2700);
    evs(9'h040, 9'h000);
    rdchk(`OFF_PROC_STATE, 32'h1);
    evs(9'h080, 9'h000);
    rdchk(`OFF_PROC_STATE, 32'h9);
    chk(bus_cycles_enable_out, 1'b0);
    evs(9'h100, 9'h000);
    chk(stopped_out, 1'b0);
    apb(1'b0, 12'h020, 32'h0);
    chk({err, rd}, 33'h100000000);
    apb(1'b1, `OFF_CONTROL, 32'h1);
    rdchk(`OFF_CONTROL, 32'h1);
    mmu_enable_in <= 1'b1;
    ins(1'b1, op_return_exc, 16'h0700);
    chk({supervisor_out, stack_select_out}, {1'b0, sp_user});
    chk(function_code_outputs_out, `FC_USER_PROGRAM);
    chk(user_block_out, 1'b1);
    cpu_space_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    chk(function_code_outputs_out, `FC_CPU_SPACE);
    cpu_space_in <= 1'b0;
    program_access_in <= 1'b0;
    evs(9'h080, 9'h000);
    chk(stopped_out, 1'b0);
    chk(function_code_outputs_out, `FC_USER_DATA);
    ins(1'b1, op_move_to_sr, 16'h3700);
    rdchk(`OFF_STATUS_REG, 32'h2700);
    chk({supervisor_out, user_block_out}, 2'b10);
    evs(9'h040, 9'h000);
    evs(9'h001, 9'h010);
    rdchk(`OFF_PROC_STATE, 32'h4);
    evs(9'h040, 9'h100);
    chk({halted_out, bus_cycles_enable_out}, 2'b10);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rdchk(`OFF_PROC_STATE, 32'h1);
    end_sim();
  end
endmodule
